// ==== pin_direction_pkg.sv ====
// constants for the pin direction control block
// assumes a 32-bit ahb-lite register bus, one slave
package pin_direction_pkg;
    localparam int unsigned PINS_PER_GROUP = 32;
    localparam int unsigned GROUP_COUNT = 2;
    localparam int unsigned GROUP_SEL_W = 1;
    localparam logic [11:0] GROUP_STRIDE = 12'h080;
    localparam int unsigned GROUP_LSB = 7;
    localparam logic [6:0] OFS_DIRECTION = 7'h00;
    localparam logic [6:0] OFS_CLEAR = 7'h04;
    localparam logic [6:0] OFS_SET = 7'h08;
    localparam logic [6:0] OFS_TOGGLE = 7'h0C;
    localparam logic [31:0] DIRECTION_RESET = 32'h00000000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic [2:0] HSIZE_HALF = 3'h1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    typedef enum logic [1:0] {
        OP_WRITE = 2'h0,
        OP_CLEAR = 2'h1,
        OP_SET = 2'h2,
        OP_TOGGLE = 2'h3
    } dir_op_t;
endpackage

// ==== pin_direction_group.sv ====
// one pin group: stored direction vector and its alias updates
// assumes a one-cycle write strobe with a byte-lane mask from the bus slave
`timescale 1ns/10ps
`default_nettype none
module pin_direction_group (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // write request
    input wire logic wr_en,
    input wire pin_direction_pkg::dir_op_t wr_op,
    input wire logic [31:0] wr_data,
    input wire logic [31:0] wr_mask,
    // state
    output logic [31:0] direction_q
);
    logic [31:0] direction_d;

    always_comb
    begin
        direction_d = direction_q;
        case (wr_op)
            pin_direction_pkg::OP_WRITE:
                direction_d = (direction_q & ~wr_mask) | (wr_data & wr_mask);
            pin_direction_pkg::OP_CLEAR:
                direction_d = direction_q & ~(wr_data & wr_mask);
            pin_direction_pkg::OP_SET:
                direction_d = direction_q | (wr_data & wr_mask);
            pin_direction_pkg::OP_TOGGLE:
                direction_d = direction_q ^ (wr_data & wr_mask);
            default:
                direction_d = direction_q;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            direction_q <= pin_direction_pkg::DIRECTION_RESET;
        else if (wr_en)
            direction_q <= direction_d;
    end

    property p_clear_only_clears;
        @(posedge hclk) disable iff (!hresetn)
        (wr_en && wr_op == pin_direction_pkg::OP_CLEAR) |=>
            ((direction_q & ~$past(wr_data & wr_mask)) == $past(direction_q & ~(wr_data & wr_mask)))
            && ((direction_q & $past(wr_data & wr_mask)) == 32'h00000000);
    endproperty
    a_clear_only_clears: assert property (p_clear_only_clears)
        else $error("clear alias changed unselected bits or left selected set");

    property p_toggle_inverts;
        @(posedge hclk) disable iff (!hresetn)
        (wr_en && wr_op == pin_direction_pkg::OP_TOGGLE) |=>
            (direction_q == ($past(direction_q) ^ $past(wr_data & wr_mask)));
    endproperty
    a_toggle_inverts: assert property (p_toggle_inverts)
        else $error("toggle alias result wrong");

    property p_hold_without_write;
        @(posedge hclk) disable iff (!hresetn)
        !wr_en |=> $stable(direction_q);
    endproperty
    a_hold_without_write: assert property (p_hold_without_write)
        else $error("direction changed without a write");
endmodule // pin_direction_group
`default_nettype wire

// ==== pin_direction_control.sv ====
// ahb-lite slave holding the direction vector of each pin group
// assumes a single ahb-lite master; hready is this slave's hreadyout
`timescale 1ns/10ps
`default_nettype none
module pin_direction_control (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // write protection
    input wire logic peripheral_write_guard,
    // pin direction to the pad logic
    output logic [31:0] pin_output_enable_g0_q,
    output logic [31:0] pin_output_enable_g1_q
);
    localparam int unsigned NG = pin_direction_pkg::GROUP_COUNT;

    logic wr_pend_q;
    logic [pin_direction_pkg::GROUP_SEL_W-1:0] wr_group_q;
    pin_direction_pkg::dir_op_t wr_op_q;
    logic [31:0] wr_mask_q;
    logic wr_block_q;
    logic [31:0] dir_vec [NG];
    logic [NG-1:0] grp_wr;
    logic addr_valid;
    logic [6:0] ofs;
    logic [pin_direction_pkg::GROUP_SEL_W-1:0] grp;
    logic [31:0] rd_d;
    logic [31:0] lane_mask;

    // byte lanes touched by a transfer
    function automatic logic [31:0] lanes(input logic [2:0] size, input logic [1:0] a);
        logic [31:0] m;
        m = 32'h00000000;
        case (size)
            pin_direction_pkg::HSIZE_BYTE: m = 32'h000000FF << {a, 3'h0};
            pin_direction_pkg::HSIZE_HALF: m = a[1] ? 32'hFFFF0000 : 32'h0000FFFF;
            default: m = 32'hFFFFFFFF;
        endcase
        return m;
    endfunction

    // offset within a group to alias operation
    function automatic pin_direction_pkg::dir_op_t op_of(input logic [6:0] o);
        pin_direction_pkg::dir_op_t r;
        r = pin_direction_pkg::OP_WRITE;
        case ({o[6:2], 2'h0})
            pin_direction_pkg::OFS_CLEAR: r = pin_direction_pkg::OP_CLEAR;
            pin_direction_pkg::OFS_SET: r = pin_direction_pkg::OP_SET;
            pin_direction_pkg::OFS_TOGGLE: r = pin_direction_pkg::OP_TOGGLE;
            default: r = pin_direction_pkg::OP_WRITE;
        endcase
        return r;
    endfunction

    assign ofs = haddr[pin_direction_pkg::GROUP_LSB-1:0];
    assign grp = haddr[pin_direction_pkg::GROUP_LSB +: pin_direction_pkg::GROUP_SEL_W];
    assign addr_valid = (haddr[11:pin_direction_pkg::GROUP_LSB+pin_direction_pkg::GROUP_SEL_W]
                         == '0) && ({ofs[6:2], 2'h0} <= pin_direction_pkg::OFS_TOGGLE);
    assign lane_mask = lanes(hsize, haddr[1:0]);

    logic req;
    assign req = hsel && hready && (htrans == pin_direction_pkg::HTRANS_NONSEQ
                                    || htrans == pin_direction_pkg::HTRANS_SEQ);

    // address phase capture for writes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_group_q <= '0;
            wr_op_q <= pin_direction_pkg::OP_WRITE;
            wr_mask_q <= 32'h00000000;
            wr_block_q <= 1'b0;
        end
        else
        begin
            wr_pend_q <= req && hwrite && addr_valid;
            if (req && hwrite)
            begin
                wr_group_q <= grp;
                wr_op_q <= op_of(ofs);
                wr_mask_q <= lane_mask;
                wr_block_q <= peripheral_write_guard;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NG; g++)
        begin : gen_group
            assign grp_wr[g] = wr_pend_q && !wr_block_q && (wr_group_q == g);
            pin_direction_group u_group (
                .hclk(hclk),
                .hresetn(hresetn),
                .wr_en(grp_wr[g]),
                .wr_op(wr_op_q),
                .wr_data(hwdata),
                .wr_mask(wr_mask_q),
                .direction_q(dir_vec[g])
            );
        end
    endgenerate

    always_comb
    begin
        rd_d = 32'h00000000;
        if (req && !hwrite && addr_valid)
            rd_d = dir_vec[grp];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (req)
            hrdata <= rd_d;
    end

    // zero wait states, always okay
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // direction to pads, registered one more stage
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_output_enable_g0_q <= pin_direction_pkg::DIRECTION_RESET;
            pin_output_enable_g1_q <= pin_direction_pkg::DIRECTION_RESET;
        end
        else
        begin
            pin_output_enable_g0_q <= dir_vec[0];
            pin_output_enable_g1_q <= dir_vec[1];
        end
    end

    property p_guard_blocks;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend_q && wr_block_q) |=> ($stable(dir_vec[0]) && $stable(dir_vec[1]));
    endproperty
    a_guard_blocks: assert property (p_guard_blocks)
        else $error("guarded write changed direction");

    property p_set_sets;
        @(posedge hclk) disable iff (!hresetn)
        (grp_wr[0] && wr_op_q == pin_direction_pkg::OP_SET) |=>
            (dir_vec[0] == ($past(dir_vec[0]) | $past(hwdata & wr_mask_q)));
    endproperty
    a_set_sets: assert property (p_set_sets)
        else $error("set alias result wrong");

    // pads follow vector after one cycle
    property p_pads_follow;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> (pin_output_enable_g1_q == $past(dir_vec[1]));
    endproperty
    a_pads_follow: assert property (p_pads_follow)
        else $error("pad direction does not follow vector");

    sequence s_read_req;
        req && !hwrite && addr_valid && grp == 1'b0;
    endsequence
    property p_read_vec;
        @(posedge hclk) disable iff (!hresetn)
        s_read_req |=> (hrdata == $past(dir_vec[0]));
    endproperty
    a_read_vec: assert property (p_read_vec)
        else $error("read data does not match direction vector");

    // byte write touches only its lane
    property p_byte_lane;
        @(posedge hclk) disable iff (!hresetn)
        (grp_wr[0] && wr_mask_q == 32'h000000FF) |=>
            (dir_vec[0][31:8] == $past(dir_vec[0][31:8]));
    endproperty
    a_byte_lane: assert property (p_byte_lane)
        else $error("byte write disturbed other lanes");

    property p_reset_zero;
        @(posedge hclk) $rose(hresetn) |-> (dir_vec[0] == 32'h00000000);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("direction not zero after reset");

    property p_ready_okay;
        @(posedge hclk) disable iff (!hresetn)
        req |=> (hreadyout && !hresp);
    endproperty
    a_ready_okay: assert property (p_ready_okay)
        else $error("transfer not answered ready and okay");

    property p_unmapped_ignored;
        @(posedge hclk) disable iff (!hresetn)
        (req && hwrite && !addr_valid) |=> !wr_pend_q;
    endproperty
    a_unmapped_ignored: assert property (p_unmapped_ignored)
        else $error("unmapped write was accepted");

    property p_unmapped_read_zero;
        @(posedge hclk) disable iff (!hresetn)
        (req && !hwrite && !addr_valid) |=> (hrdata == 32'h00000000);
    endproperty
    a_unmapped_read_zero: assert property (p_unmapped_read_zero)
        else $error("unmapped read returned nonzero data");

    sequence s_read_req_g1;
        req && !hwrite && addr_valid && grp == 1'b1;
    endsequence
    property p_read_vec_g1;
        @(posedge hclk) disable iff (!hresetn)
        s_read_req_g1 |=> (hrdata == $past(dir_vec[1]));
    endproperty
    a_read_vec_g1: assert property (p_read_vec_g1)
        else $error("group one read data does not match vector");

    property p_group_isolation;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend_q && wr_group_q == 1'b0) |=> $stable(dir_vec[1]);
    endproperty
    a_group_isolation: assert property (p_group_isolation)
        else $error("group zero write changed group one");

    property p_clear_g1;
        @(posedge hclk) disable iff (!hresetn)
        (grp_wr[1] && wr_op_q == pin_direction_pkg::OP_CLEAR) |=>
            ((dir_vec[1] & $past(hwdata & wr_mask_q)) == 32'h00000000);
    endproperty
    a_clear_g1: assert property (p_clear_g1)
        else $error("clear alias left selected bits set");

    property p_pads_follow_g0;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> (pin_output_enable_g0_q == $past(dir_vec[0]));
    endproperty
    a_pads_follow_g0: assert property (p_pads_follow_g0)
        else $error("group zero pad direction does not follow vector");

    property p_half_lane;
        @(posedge hclk) disable iff (!hresetn)
        (grp_wr[1] && wr_mask_q == 32'hFFFF0000) |=>
            (dir_vec[1][15:0] == $past(dir_vec[1][15:0]));
    endproperty
    a_half_lane: assert property (p_half_lane)
        else $error("halfword write disturbed lower half");

    sequence s_guarded_write;
        req && hwrite && addr_valid && peripheral_write_guard;
    endsequence
    property p_guard_captured;
        @(posedge hclk) disable iff (!hresetn)
        s_guarded_write |=> (wr_pend_q && wr_block_q && !grp_wr[0] && !grp_wr[1]);
    endproperty
    a_guard_captured: assert property (p_guard_captured)
        else $error("guarded write still enabled a group");
endmodule // pin_direction_control
`default_nettype wire

// ==== ahb_master_model.sv ====
// partner model: ahb-lite master issuing single transfers
// assumes the slave's hreadyout is fed back as hready
`timescale 1ns/10ps
`default_nettype none
module ahb_master_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // request side
    input wire logic start,
    input wire logic [11:0] req_addr,
    input wire logic req_write,
    input wire logic [2:0] req_size,
    input wire logic [31:0] req_wdata,
    output logic done,
    output logic [31:0] rdata,
    // ahb-lite master
    output logic hsel,
    output logic [11:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    logic [1:0] phase_q;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase_q <= 2'h0;
            done <= 1'b0;
            hsel <= 1'b0;
            htrans <= 2'h0;
            haddr <= 12'h000;
            hwrite <= 1'b0;
            hsize <= 3'h0;
            hwdata <= 32'h00000000;
            rdata <= 32'h00000000;
        end
        else
        begin
            done <= 1'b0;
            case (phase_q)
            2'h0:
                if (start && !done)
                begin
                    hsel <= 1'b1;
                    haddr <= req_addr;
                    hwrite <= req_write;
                    hsize <= req_size;
                    htrans <= pin_direction_pkg::HTRANS_NONSEQ;
                    phase_q <= 2'h1;
                end
            2'h1:
                if (hready)
                begin
                    hsel <= 1'b0;
                    htrans <= 2'h0;
                    hwdata <= req_wdata;
                    phase_q <= 2'h2;
                end
            default:
                if (hready)
                begin
                    rdata <= hrdata;
                    done <= 1'b1;
                    hwdata <= ~hwdata;
                    phase_q <= 2'h0;
                end
            endcase
        end
    end
endmodule // ahb_master_model
`default_nettype wire

// ==== pin_direction_control_tb.sv ====
// self-checking bench for the pin direction control block
// assumes the master model above as the only bus master
`timescale 1ns/10ps
`default_nettype none
module pin_direction_control_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic start = 1'b0;
    logic [11:0] req_addr = 12'h000;
    logic req_write = 1'b0;
    logic [2:0] req_size = 3'h0;
    logic [31:0] req_wdata = 32'h00000000;
    logic guard = 1'b0;
    logic done, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [11:0] haddr;
    logic [31:0] rdata, hwdata, hrdata, pads0, pads1;
    logic [31:0] exp_dir [2] = '{32'h00000000, 32'h00000000};
    int bad_count = 0;
    int checks_done = 0;
    always #12.5 hclk = ~hclk;
    ahb_master_model i_ahb_master_model (.hclk(hclk), .hresetn(hresetn), .start(start),
        .req_addr(req_addr), .req_write(req_write), .req_size(req_size),
        .req_wdata(req_wdata), .done(done), .rdata(rdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata));
    pin_direction_control i_pin_direction_control (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .peripheral_write_guard(guard),
        .pin_output_enable_g0_q(pads0), .pin_output_enable_g1_q(pads1));
    // ==========================================
    // helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic xfer(input logic [11:0] a, input logic w, input logic [2:0] s,
        input logic [31:0] d);
        int n;
        n = 0;
        // one edge apart from the previous release of start
        @(posedge hclk);
        start <= 1'b1;
        req_addr <= a;
        req_write <= w;
        req_size <= s;
        req_wdata <= d;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (done !== 1'b1 && n < 20);
        start <= 1'b0;
        if (done !== 1'b1)
        begin
            bad_count++;
            tally_and_finish();
        end
        check("response", 32'(hresp), 32'h00000000);
        check("ready", 32'(hreadyout), 32'h00000001);
    endtask
    task automatic rd(input logic [11:0] a, input string what, input logic [31:0] want);
        xfer(a, 1'b0, pin_direction_pkg::HSIZE_WORD, 32'h00000000);
        check(what, rdata, want);
    endtask
    function automatic logic [31:0] lane_mask(input logic [2:0] s, input logic [1:0] a);
        if (s == pin_direction_pkg::HSIZE_WORD)
            return 32'hFFFFFFFF;
        if (s == pin_direction_pkg::HSIZE_HALF)
            return a[1] ? 32'hFFFF0000 : 32'h0000FFFF;
        return 32'h000000FF << (8 * a);
    endfunction
    function automatic logic [31:0] apply(input logic [31:0] v, input logic [1:0] op,
        input logic [31:0] d, input logic [31:0] m);
        case (op)
        2'h0: return (v & ~m) | (d & m);
        2'h1: return v & ~(d & m);
        2'h2: return v | (d & m);
        default: return v ^ (d & m);
        endcase
    endfunction
    // ==========================================
    // main sequence
    initial
    begin
        int i;
        logic g;
        logic [1:0] op, ln;
        logic [2:0] sz;
        logic [31:0] d;
        void'($urandom(63));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        for (i = 0; i < 8; i++)
            rd({4'h0, i[2], 3'h0, i[1:0], 2'h0}, "reset value", 32'h00000000);
        check("pads after reset", pads0 | pads1, 32'h00000000);
        $display("test reset values done");
        for (i = 0; i < 80; i++)
        begin
            g = 1'($urandom);
            op = 2'($urandom);
            sz = (i < 6) ? pin_direction_pkg::HSIZE_WORD : 3'($urandom % 3);
            ln = 2'($urandom);
            d = (i < 3) ? 32'hFFFFFFFF : $urandom;
            if (sz == pin_direction_pkg::HSIZE_WORD)
                ln = 2'h0;
            if (sz == pin_direction_pkg::HSIZE_HALF)
                ln[0] = 1'b0;
            xfer({4'h0, g, 3'h0, op, ln}, 1'b1, sz, d);
            exp_dir[g] = apply(exp_dir[g], op, d, lane_mask(sz, ln));
            rd({4'h0, g, 3'h0, 2'($urandom), 2'h0}, "vector", exp_dir[g]);
            check("pads", g ? pads1 : pads0, exp_dir[g]);
            check("other group", g ? pads0 : pads1, exp_dir[~g]);
        end
        $display("test alias traffic done");
        guard <= 1'b1;
        xfer(12'h008, 1'b1, pin_direction_pkg::HSIZE_WORD, 32'hA5A5A5A5);
        xfer(12'h08C, 1'b1, pin_direction_pkg::HSIZE_HALF, 32'hFFFFFFFF);
        guard <= 1'b0;
        rd(12'h000, "guarded group0", exp_dir[0]);
        rd(12'h080, "guarded group1", exp_dir[1]);
        $display("test write guard done");
        xfer(12'h108, 1'b1, pin_direction_pkg::HSIZE_WORD, 32'hFFFFFFFF);
        xfer(12'h010, 1'b1, pin_direction_pkg::HSIZE_WORD, 32'hFFFFFFFF);
        rd(12'h108, "unmapped read", 32'h00000000);
        rd(12'h004, "after unmapped", exp_dir[0]);
        $display("test unmapped done");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rd(12'h088, "second reset", 32'h00000000);
        check("pads after second reset", pads0 | pads1, 32'h00000000);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule // pin_direction_control_tb
`default_nettype wire
